// ---- verilog/fiir_pkg.sv ----
// constants, types and command layout for the fault-injection and id register bank
package fiir_pkg;

    // command codes
    localparam logic [7:0]  FIIR_CMD_FAULT_INJ  = 8'hF1;
    localparam logic [7:0]  FIIR_CMD_ID_WORD    = 8'hFC;
    localparam logic [7:0]  FIIR_CMD_ID_BLOCK   = 8'hFD;

    // answer lengths in bytes
    localparam logic [2:0]  FIIR_LEN_WORD       = 3'h2;
    localparam logic [2:0]  FIIR_LEN_BLOCK      = 3'h6;

    // fault_injection_control bit positions
    localparam int          FIIR_FAULT_HOLD_BIT = 15;
    localparam int          FIIR_OVT_F_BIT      = 14;
    localparam int          FIIR_OC_F_BIT       = 12;
    localparam int          FIIR_IN_LOCK_BIT    = 11;
    localparam int          FIIR_IN_OV_F_BIT    = 10;
    localparam int          FIIR_OUT_UV_F_BIT   = 9;
    localparam int          FIIR_OUT_OV_F_BIT   = 8;
    localparam int          FIIR_WARN_HOLD_BIT  = 7;
    localparam int          FIIR_OC_W_BIT       = 4;
    localparam int          FIIR_IN_UV_W_BIT    = 3;
    localparam int          FIIR_OUT_UV_W_BIT   = 1;
    localparam int          FIIR_OUT_OV_W_BIT   = 0;

    // injection bits cleared by a fault or a warning response, and the reserved bits
    localparam logic [15:0] FIIR_FAULT_INJ_MASK = 16'h5F00;
    localparam logic [15:0] FIIR_WARN_INJ_MASK  = 16'h001B;
    localparam logic [15:0] FIIR_RSVD_MASK      = 16'h2064;

    // reset values: fault half is zero, warning half is a default setting
    localparam logic [7:0]  FIIR_FAULT_RST      = 8'h00;
    localparam logic [7:0]  FIIR_WARN_RST_DFLT  = 8'h00;

    // id values, arbitrary neutral codes
    localparam logic [15:0] FIIR_ID_WORD_DFLT   = 16'h1234;
    localparam logic [47:0] FIIR_ID_BLOCK_DFLT  = 48'hA5A5_0102_0304;

    // detectors that an injection may trip while conversion is off
    localparam logic [9:0]  FIIR_DET_ALWAYS     = 10'h090;

    typedef enum logic [3:0]
    {
        FIIR_WR_WORD  = 4'h1,
        FIIR_RD_WORD  = 4'h2,
        FIIR_WR_BLOCK = 4'h4,
        FIIR_RD_BLOCK = 4'h8
    } fiir_kind_t;

    // detector outputs, msb first
    typedef struct packed
    {
        logic ovt_f;
        logic oc_f;
        logic in_lockout;
        logic in_ov_f;
        logic out_uv_f;
        logic out_ov_f;
        logic oc_w;
        logic in_uv_w;
        logic out_uv_w;
        logic out_ov_w;
    } fiir_det_t;

    typedef struct packed
    {
        logic       valid;
        fiir_kind_t kind;
        logic [7:0] code;
        logic [15:0] data;
    } fiir_cmd_t;

    typedef struct packed
    {
        logic        ack;
        logic        hit;
        logic        cml;
        logic [2:0]  len;
        logic [47:0] data;
    } fiir_rsp_t;

endpackage

// ---- verilog/fiir_sync2.sv ----
// two-flop synchroniser for asynchronous detector levels
`timescale 1ns/1ps
module fiir_sync2
#(
    parameter int WIDTH = 10
)
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;

endmodule

// ---- verilog/fiir_force_cell.sv ----
// one detector output: real trip or gated injection
`timescale 1ns/1ps
module fiir_force_cell
#(
    parameter bit ALWAYS_OK = 1'b0
)
(
    input  wire logic i_clk_sys,
    input  wire logic i_rst,
    input  wire logic i_raw,
    input  wire logic i_inject,
    input  wire logic i_conv_en,
    output logic      o_force
);

    logic force_r;

    // injection forces the detector output while i_conv_en or ALWAYS_OK is set, real trips pass unchanged
    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            force_r <= 1'b0;
        else
            force_r <= i_raw | (i_inject & (ALWAYS_OK | i_conv_en));
    end

    assign o_force = force_r;

endmodule

// ---- verilog/fiir_regs.sv ----
// fault-injection control register, id registers and forced detector outputs
`timescale 1ns/1ps
module fiir_regs
    import fiir_pkg::*;
#(
    parameter logic [7:0]  WARN_RST = fiir_pkg::FIIR_WARN_RST_DFLT,
    parameter logic [15:0] ID_WORD  = fiir_pkg::FIIR_ID_WORD_DFLT,
    parameter logic [47:0] ID_BLOCK = fiir_pkg::FIIR_ID_BLOCK_DFLT
)
(
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  wire fiir_pkg::fiir_cmd_t i_cmd,
    input  wire logic                i_conv_en,
    input  wire logic                i_fault_resp,
    input  wire logic                i_warn_resp,
    input  wire fiir_pkg::fiir_det_t i_det_raw,
    output fiir_pkg::fiir_det_t      o_det,
    output fiir_pkg::fiir_rsp_t      o_rsp,
    output logic [15:0]              o_inject_ctrl
);
    import fiir_pkg::*;

    logic [15:0] fault_injection_control_r;
    logic [15:0] fault_injection_control_nxt;
    fiir_rsp_t   rsp_r;
    fiir_rsp_t   rsp_nxt;
    fiir_det_t   det_sync;
    fiir_det_t   inject_vec;
    fiir_det_t   det_force;
    logic        wr_ctrl;
    logic        is_ours;
    logic        kind_ok;

    // comparators are asynchronous to this clock
    fiir_sync2
    #(
        .WIDTH    ($bits(fiir_det_t))
    )
    u_det_sync
    (
        .i_clk_sys(i_clk_sys),
        .i_rst    (i_rst),
        .i_async  (i_det_raw),
        .o_sync   (det_sync)
    );

    assign wr_ctrl = i_cmd.valid && (i_cmd.kind == FIIR_WR_WORD) && (i_cmd.code == FIIR_CMD_FAULT_INJ);

    // register update: a write wins over a response clear
    always_comb
    begin
        fault_injection_control_nxt = fault_injection_control_r;
        if (i_fault_resp && !fault_injection_control_r[FIIR_FAULT_HOLD_BIT])
            fault_injection_control_nxt = fault_injection_control_nxt & ~FIIR_FAULT_INJ_MASK;
        if (i_warn_resp && !fault_injection_control_r[FIIR_WARN_HOLD_BIT])
            fault_injection_control_nxt = fault_injection_control_nxt & ~FIIR_WARN_INJ_MASK;
        if (wr_ctrl)
            fault_injection_control_nxt = i_cmd.data;
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            fault_injection_control_r <= {FIIR_FAULT_RST, WARN_RST};
        else
            fault_injection_control_r <= fault_injection_control_nxt;
    end

    // reserved bits are not mapped onto any detector
    always_comb
    begin
        inject_vec            = '0;
        inject_vec.ovt_f      = fault_injection_control_r[FIIR_OVT_F_BIT];
        inject_vec.oc_f       = fault_injection_control_r[FIIR_OC_F_BIT];
        inject_vec.in_lockout = fault_injection_control_r[FIIR_IN_LOCK_BIT];
        inject_vec.in_ov_f    = fault_injection_control_r[FIIR_IN_OV_F_BIT];
        inject_vec.out_uv_f   = fault_injection_control_r[FIIR_OUT_UV_F_BIT];
        inject_vec.out_ov_f   = fault_injection_control_r[FIIR_OUT_OV_F_BIT];
        inject_vec.oc_w       = fault_injection_control_r[FIIR_OC_W_BIT];
        inject_vec.in_uv_w    = fault_injection_control_r[FIIR_IN_UV_W_BIT];
        inject_vec.out_uv_w   = fault_injection_control_r[FIIR_OUT_UV_W_BIT];
        inject_vec.out_ov_w   = fault_injection_control_r[FIIR_OUT_OV_W_BIT];
    end

    // one cell per detector, gated by conversion enable where required
    for (genvar g = 0; g < $bits(fiir_det_t); g++)
    begin : g_cell
        fiir_force_cell
        #(
            .ALWAYS_OK(FIIR_DET_ALWAYS[g])
        )
        u_cell
        (
            .i_clk_sys(i_clk_sys),
            .i_rst    (i_rst),
            .i_raw    (det_sync[g]),
            .i_inject (inject_vec[g]),
            .i_conv_en(i_conv_en),
            .o_force  (det_force[g])
        );
    end

    // command decode and answer
    always_comb
    begin
        is_ours = (i_cmd.code == FIIR_CMD_FAULT_INJ) || (i_cmd.code == FIIR_CMD_ID_WORD)
                  || (i_cmd.code == FIIR_CMD_ID_BLOCK);
        unique case (i_cmd.code)
            FIIR_CMD_ID_BLOCK:
                kind_ok = (i_cmd.kind == FIIR_WR_BLOCK) || (i_cmd.kind == FIIR_RD_BLOCK);
            default:
                kind_ok = (i_cmd.kind == FIIR_WR_WORD) || (i_cmd.kind == FIIR_RD_WORD);
        endcase
        rsp_nxt      = '0;
        rsp_nxt.ack  = i_cmd.valid && is_ours;
        rsp_nxt.hit  = i_cmd.valid && is_ours && kind_ok;
        // only a wrong transaction type is a communication error
        rsp_nxt.cml  = i_cmd.valid && is_ours && !kind_ok;
        if (i_cmd.valid && is_ours && kind_ok)
        begin
            unique case (i_cmd.code)
                FIIR_CMD_ID_WORD:
                begin
                    rsp_nxt.len  = FIIR_LEN_WORD;
                    rsp_nxt.data = {32'h0000_0000, ID_WORD};
                end
                FIIR_CMD_ID_BLOCK:
                begin
                    rsp_nxt.len  = FIIR_LEN_BLOCK;
                    rsp_nxt.data = ID_BLOCK;
                end
                default:
                begin
                    rsp_nxt.len  = FIIR_LEN_WORD;
                    rsp_nxt.data = {32'h0000_0000, fault_injection_control_r};
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys)
    begin
        if (i_rst)
            rsp_r <= '0;
        else
            rsp_r <= rsp_nxt;
    end

    assign o_rsp         = rsp_r;
    assign o_det         = det_force;
    assign o_inject_ctrl = fault_injection_control_r;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_rst);

    logic id_wr;
    assign id_wr = i_cmd.valid && ((i_cmd.code == FIIR_CMD_ID_WORD && i_cmd.kind == FIIR_WR_WORD)
                   || (i_cmd.code == FIIR_CMD_ID_BLOCK && i_cmd.kind == FIIR_WR_BLOCK));

    fault_oneshot_a: assert property (
        (i_fault_resp && !fault_injection_control_r[FIIR_FAULT_HOLD_BIT] && !wr_ctrl)
        |=> ((fault_injection_control_r & FIIR_FAULT_INJ_MASK) == 16'h0000))
        else $error("one-shot fault injection not cleared by response");

    fault_persist_a: assert property (
        (i_fault_resp && fault_injection_control_r[FIIR_FAULT_HOLD_BIT] && !wr_ctrl)
        |=> $stable(fault_injection_control_r & FIIR_FAULT_INJ_MASK))
        else $error("persistent fault injection changed by response");

    warn_oneshot_a: assert property (
        (i_warn_resp && !fault_injection_control_r[FIIR_WARN_HOLD_BIT] && !wr_ctrl)
        |=> ((fault_injection_control_r & FIIR_WARN_INJ_MASK) == 16'h0000))
        else $error("one-shot warning injection not cleared by response");

    warn_persist_a: assert property (
        (i_warn_resp && fault_injection_control_r[FIIR_WARN_HOLD_BIT] && !wr_ctrl)
        |=> $stable(fault_injection_control_r & FIIR_WARN_INJ_MASK))
        else $error("persistent warning injection changed by response");

    ovt_gated_a: assert property (
        (fault_injection_control_r[FIIR_OVT_F_BIT] && i_conv_en)
        |=> o_det.ovt_f)
        else $error("overtemperature injection did not force detector");

    ovt_off_a: assert property (
        (!i_conv_en && !det_sync.ovt_f) |=> !o_det.ovt_f)
        else $error("overtemperature injected while conversion disabled");

    lockout_always_a: assert property (
        (fault_injection_control_r[FIIR_IN_LOCK_BIT] && !i_conv_en) |=> o_det.in_lockout)
        else $error("lockout injection blocked while conversion disabled");

    reserved_quiet_a: assert property (
        (((fault_injection_control_r & ~FIIR_RSVD_MASK) == 16'h0000) && det_sync == '0) |=> (o_det == '0))
        else $error("reserved bit reached a detector");

    write_all_a: assert property (
        wr_ctrl |=> (fault_injection_control_r == $past(i_cmd.data)) ##1 (o_det.out_ov_f == $past(i_cmd.data[8], 2)
                     || $past(det_sync.out_ov_f)))
        else $error("word write not loaded in full");

    id_write_a: assert property (
        id_wr |=> (rsp_r.ack && rsp_r.hit && !rsp_r.cml))
        else $error("id write not accepted cleanly");

    id_stable_a: assert property (
        (id_wr && !i_fault_resp && !i_warn_resp)
        |=> $stable(fault_injection_control_r))
        else $error("id write changed the control register");

    id_read_a: assert property (
        (i_cmd.valid && i_cmd.code == FIIR_CMD_ID_BLOCK && i_cmd.kind == FIIR_RD_BLOCK)
        |=> (rsp_r.data == ID_BLOCK && rsp_r.len == FIIR_LEN_BLOCK))
        else $error("id block readback wrong");

    reset_val_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        i_rst |=> (fault_injection_control_r[15:8] == FIIR_FAULT_RST))
        else $error("fault half not zero after reset");

    reset_det_a: assert property (@(posedge i_clk_sys) disable iff (1'b0)
        i_rst |=> (o_det == '0 && rsp_r == '0))
        else $error("detector or answer not cleared by reset");

    // each injection bit forces its own detector
    ovt_quiet_a: assert property (
        (!fault_injection_control_r[FIIR_OVT_F_BIT] && !det_sync.ovt_f)
        |=> !o_det.ovt_f)
        else $error("overtemperature forced without injection or trip");

    oc_fault_a: assert property (
        (fault_injection_control_r[FIIR_OC_F_BIT] && i_conv_en)
        |=> o_det.oc_f)
        else $error("overcurrent fault injection did not force detector");

    lockout_force_a: assert property (
        fault_injection_control_r[FIIR_IN_LOCK_BIT]
        |=> o_det.in_lockout)
        else $error("lockout injection did not force detector");

    lockout_quiet_a: assert property (
        (!fault_injection_control_r[FIIR_IN_LOCK_BIT] && !det_sync.in_lockout)
        |=> !o_det.in_lockout)
        else $error("lockout forced without injection or trip");

    in_ov_fault_a: assert property (
        (fault_injection_control_r[FIIR_IN_OV_F_BIT] && i_conv_en)
        |=> o_det.in_ov_f)
        else $error("input overvoltage injection did not force detector");

    out_uv_fault_a: assert property (
        (fault_injection_control_r[FIIR_OUT_UV_F_BIT] && i_conv_en)
        |=> o_det.out_uv_f)
        else $error("output undervoltage injection did not force detector");

    out_ov_fault_a: assert property (
        fault_injection_control_r[FIIR_OUT_OV_F_BIT]
        |=> o_det.out_ov_f)
        else $error("output overvoltage injection did not force detector");

    oc_warn_a: assert property (
        (fault_injection_control_r[FIIR_OC_W_BIT] && i_conv_en)
        |=> o_det.oc_w)
        else $error("overcurrent warning injection did not force detector");

    in_uv_warn_a: assert property (
        (fault_injection_control_r[FIIR_IN_UV_W_BIT] && i_conv_en)
        |=> o_det.in_uv_w)
        else $error("input undervoltage warning injection did not force detector");

    out_uv_warn_a: assert property (
        (fault_injection_control_r[FIIR_OUT_UV_W_BIT] && i_conv_en)
        |=> o_det.out_uv_w)
        else $error("output undervoltage warning injection did not force detector");

    out_ov_warn_a: assert property (
        (fault_injection_control_r[FIIR_OUT_OV_W_BIT] && i_conv_en)
        |=> o_det.out_ov_w)
        else $error("output overvoltage warning injection did not force detector");

    // conversion gating and real trips
    gated_off_a: assert property (
        (!i_conv_en && ((det_sync & ~FIIR_DET_ALWAYS) == 10'h000))
        |=> ((o_det & ~FIIR_DET_ALWAYS) == 10'h000))
        else $error("gated injection acted while conversion disabled");

    raw_pass_a: assert property (
        (det_sync != '0)
        |=> ((o_det & $past(det_sync)) == $past(det_sync)))
        else $error("real detector trip did not pass through");

    rsvd_keep_a: assert property (
        ((i_fault_resp || i_warn_resp) && !wr_ctrl)
        |=> $stable(fault_injection_control_r & FIIR_RSVD_MASK))
        else $error("reserved bits changed by a response");

    // command answers
    id_word_a: assert property (
        (i_cmd.valid && i_cmd.code == FIIR_CMD_ID_WORD && i_cmd.kind == FIIR_RD_WORD)
        |=> (rsp_r.data == {32'h0000_0000, ID_WORD} && rsp_r.len == FIIR_LEN_WORD))
        else $error("id word readback wrong");

    wrong_kind_a: assert property (
        (i_cmd.valid && i_cmd.code == FIIR_CMD_FAULT_INJ && !i_fault_resp && !i_warn_resp
         && (i_cmd.kind == FIIR_WR_BLOCK || i_cmd.kind == FIIR_RD_BLOCK))
        |=> (rsp_r.ack && !rsp_r.hit && rsp_r.cml && $stable(fault_injection_control_r)))
        else $error("wrong transfer type at control register not refused");

    rsp_idle_a: assert property (
        !i_cmd.valid |=> (rsp_r == '0))
        else $error("answer raised without a command");

    inject_cov_c:  cover property (wr_ctrl && i_cmd.data[FIIR_OVT_F_BIT] && i_conv_en);
    persist_cov_c: cover property (i_fault_resp && fault_injection_control_r[FIIR_FAULT_HOLD_BIT]);
    id_wr_cov_c:   cover property (id_wr);
    off_cov_c:     cover property (!i_conv_en && fault_injection_control_r[FIIR_OUT_OV_F_BIT]);
    raw_cov_c:     cover property (det_sync != '0 && !i_conv_en);

endmodule

// ---- testbench/fiir_host_model.sv ----
// host-side command source for the fault-injection and id register bank
`timescale 1ns/1ps
module fiir_host_model
    import fiir_pkg::*;
(
    input  wire logic          i_clk_sys,
    output fiir_pkg::fiir_cmd_t o_cmd
);
    initial o_cmd = '0;

    // one-cycle command pulse; idle code and data show the inverse (kind is kept) so stale values are never trusted
    task automatic issue(input fiir_kind_t kind, input logic [7:0] code, input logic [15:0] data);
        @(posedge i_clk_sys);
        o_cmd <= '{valid: 1'b1, kind: kind, code: code, data: data};
        @(posedge i_clk_sys);
        o_cmd <= '{valid: 1'b0, kind: kind, code: ~code, data: ~data};
    endtask
endmodule

// ---- testbench/fiir_regs_tb.sv ----
// self-checking bench for the fault-injection and id register bank
`timescale 1ns/1ps
module fiir_regs_tb;
    import fiir_pkg::*;
    logic                i_clk_sys = 1'b0;
    logic                i_rst     = 1'b1;
    logic                i_conv_en = 1'b1;
    logic                i_fault_resp = 1'b0;
    logic                i_warn_resp  = 1'b0;
    fiir_det_t           i_det_raw = '0;
    fiir_cmd_t           i_cmd;
    fiir_det_t           o_det;
    fiir_rsp_t           o_rsp;
    fiir_rsp_t           rsp;
    logic [15:0]         o_inject_ctrl;
    int                  fail_count  = 0;
    int                  check_count = 0;
    int                  pos [10] = '{0, 1, 3, 4, 8, 9, 10, 11, 12, 14};

    always #50 i_clk_sys = ~i_clk_sys;

    fiir_host_model fiir_host_model_inst (.i_clk_sys(i_clk_sys), .o_cmd(i_cmd));

    fiir_regs fiir_regs_inst
    (
        .i_clk_sys     (i_clk_sys),
        .i_rst         (i_rst),
        .i_cmd         (i_cmd),
        .i_conv_en     (i_conv_en),
        .i_fault_resp  (i_fault_resp),
        .i_warn_resp   (i_warn_resp),
        .i_det_raw     (i_det_raw),
        .o_det         (o_det),
        .o_rsp         (o_rsp),
        .o_inject_ctrl (o_inject_ctrl)
    );

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic chk_rsp(input logic [47:0] got, input logic [47:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_det(input fiir_det_t got, input logic [9:0] exp);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    function automatic logic [47:0] hdr(input fiir_rsp_t r);
        return 48'({r.ack, r.hit, r.cml, r.len});
    endfunction

    // answer is registered on the same edge that takes the command
    task automatic acc(input fiir_kind_t k, input logic [7:0] c, input logic [15:0] d);
        fiir_host_model_inst.issue(k, c, d);
        #1;
        rsp = o_rsp;
    endtask

    task automatic step;
        @(posedge i_clk_sys);
        #1;
    endtask

    task automatic wr_step(input logic [15:0] d);
        acc(FIIR_WR_WORD, FIIR_CMD_FAULT_INJ, d);
        step();
    endtask

    task automatic rd_ctrl(input logic [15:0] exp);
        acc(FIIR_RD_WORD, FIIR_CMD_FAULT_INJ, 16'h0000);
        chk_rsp(rsp.data, 48'(exp));
        chk_rsp(48'(o_inject_ctrl), 48'(exp));
    endtask

    task automatic pulse(input logic f, input logic w);
        @(posedge i_clk_sys);
        i_fault_resp <= f;
        i_warn_resp  <= w;
        @(posedge i_clk_sys);
        i_fault_resp <= 1'b0;
        i_warn_resp  <= 1'b0;
    endtask

    task automatic t_reset;
        acc(FIIR_RD_WORD, FIIR_CMD_FAULT_INJ, 16'h0000);
        chk_rsp(hdr(rsp), 48'({3'b110, FIIR_LEN_WORD}));
        chk_rsp(48'(rsp.data[15:8]), 48'h0);
        chk_det(o_det, 10'h000);
    endtask

    task automatic t_ids;
        acc(FIIR_RD_WORD, FIIR_CMD_ID_WORD, 16'h0000);
        chk_rsp(hdr(rsp), 48'({3'b110, FIIR_LEN_WORD}));
        chk_rsp(rsp.data, 48'(FIIR_ID_WORD_DFLT));
        acc(FIIR_WR_WORD, FIIR_CMD_ID_WORD, 16'hFFFF);
        chk_rsp(48'({rsp.ack, rsp.cml}), 48'h2);
        acc(FIIR_RD_WORD, FIIR_CMD_ID_WORD, 16'h0000);
        chk_rsp(rsp.data, 48'(FIIR_ID_WORD_DFLT));
        acc(FIIR_RD_BLOCK, FIIR_CMD_ID_BLOCK, 16'h0000);
        chk_rsp(hdr(rsp), 48'({3'b110, FIIR_LEN_BLOCK}));
        chk_rsp(rsp.data, FIIR_ID_BLOCK_DFLT);
        acc(FIIR_WR_BLOCK, FIIR_CMD_ID_BLOCK, 16'h5A5A);
        chk_rsp(48'({rsp.ack, rsp.cml}), 48'h2);
        acc(FIIR_RD_BLOCK, FIIR_CMD_ID_BLOCK, 16'h0000);
        chk_rsp(rsp.data, FIIR_ID_BLOCK_DFLT);
    endtask

    // each injection bit alone, holds set so no response interferes
    task automatic t_each;
        for (int i = 0; i < 10; i++)
        begin
            wr_step(16'h8080 | (16'h0001 << pos[i]));
            chk_det(o_det, 10'h001 << i);
        end
    endtask

    task automatic t_reserved;
        wr_step(16'h2064);
        chk_det(o_det, 10'h000);
        rd_ctrl(16'h2064);
    endtask

    task automatic t_gating;
        @(posedge i_clk_sys);
        i_conv_en <= 1'b0;
        wr_step(16'hDF9B);
        chk_det(o_det, 10'h090);
        @(posedge i_clk_sys);
        i_conv_en <= 1'b1;
        step();
        step();
        chk_det(o_det, 10'h3FF);
    endtask

    task automatic t_hold;
        wr_step(16'h5F1B);
        chk_det(o_det, 10'h3FF);
        pulse(1'b1, 1'b0);
        rd_ctrl(16'h001B);
        chk_det(o_det, 10'h00F);
        pulse(1'b0, 1'b1);
        rd_ctrl(16'h0000);
        chk_det(o_det, 10'h000);
        wr_step(16'hDF9B);
        pulse(1'b1, 1'b1);
        rd_ctrl(16'hDF9B);
        chk_det(o_det, 10'h3FF);
    endtask

    // block transfers at the word register are refused, unknown codes get no answer
    task automatic t_refuse;
        wr_step(16'h8080);
        acc(FIIR_RD_BLOCK, FIIR_CMD_FAULT_INJ, 16'h0000);
        chk_rsp(hdr(rsp), 48'({3'b101, 3'h0}));
        chk_rsp(rsp.data, 48'h0);
        acc(FIIR_WR_BLOCK, FIIR_CMD_FAULT_INJ, 16'h5F1B);
        chk_rsp(48'({rsp.hit, rsp.cml}), 48'h1);
        rd_ctrl(16'h8080);
        acc(FIIR_RD_WORD, 8'hF0, 16'h0000);
        chk_rsp(hdr(rsp), 48'h0);
    endtask

    // real trips pass two sync flops and the cell, even with conversion off
    task automatic t_raw;
        wr_step(16'h8080);
        @(posedge i_clk_sys);
        i_conv_en <= 1'b0;
        i_det_raw <= 10'h155;
        step();
        step();
        chk_det(o_det, 10'h000);
        step();
        chk_det(o_det, 10'h155);
        @(posedge i_clk_sys);
        i_det_raw <= 10'h000;
        i_conv_en <= 1'b1;
        step();
        step();
        step();
        chk_det(o_det, 10'h000);
    endtask

    // a second reset in mid-run drops every injection
    task automatic t_rerst;
        @(posedge i_clk_sys);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        rd_ctrl({FIIR_FAULT_RST, FIIR_WARN_RST_DFLT});
        chk_det(o_det, 10'h000);
    endtask

    initial
    begin
        repeat (5000) @(posedge i_clk_sys);
        fail_count++;
        close_out();
    end

    initial
    begin
        repeat (2) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        t_reset();
        t_ids();
        t_refuse();
        t_each();
        t_reserved();
        t_raw();
        t_gating();
        t_hold();
        t_rerst();
        close_out();
    end
endmodule
